// file: csie_pkg.sv
package csie_pkg;

   // ==========================================================
   // Register indices and byte addresses (byte address = 4 x index)
   localparam logic [5:0] IDX_CMD_STATUS = 6'h2e;
   localparam logic [5:0] IDX_VERSION    = 6'h33;
   localparam logic [5:0] IDX_INT_EN1    = 6'h35;
   localparam logic [5:0] IDX_INT_EN2    = 6'h36;
   localparam logic [5:0] IDX_INT_STAT1  = 6'h37;
   localparam logic [5:0] IDX_INT_STAT2  = 6'h38;

   localparam logic [7:0] ADDR_CMD_STATUS = {IDX_CMD_STATUS, 2'b00};
   localparam logic [7:0] ADDR_VERSION    = {IDX_VERSION, 2'b00};
   localparam logic [7:0] ADDR_INT_EN1    = {IDX_INT_EN1, 2'b00};
   localparam logic [7:0] ADDR_INT_EN2    = {IDX_INT_EN2, 2'b00};
   localparam logic [7:0] ADDR_INT_STAT1  = {IDX_INT_STAT1, 2'b00};
   localparam logic [7:0] ADDR_INT_STAT2  = {IDX_INT_STAT2, 2'b00};

   // ==========================================================
   // Reset values and writable masks
   localparam logic [7:0] INT_EN1_RESET    = 8'hfb;
   localparam logic [7:0] INT_EN2_RESET    = 8'h40;
   localparam logic [7:0] INT_EN2_WRITABLE = 8'hc7;
   localparam logic [7:0] CMD_STATUS_RESET = 8'h00;
   localparam logic [7:0] INT_STAT_RESET   = 8'h00;
   localparam logic [7:0] VERSION_DEFAULT  = 8'h5a;  // Arbitrary value

   // ==========================================================
   // Command status bit positions
   localparam int CS_SIGNAL_STRENGTH = 7;
   localparam int CS_OSC_RANGE       = 6;
   localparam int CS_SUPPLY_LEVEL    = 5;
   localparam int CS_FILTER_CAL      = 4;
   localparam int CS_ADC             = 3;
   localparam int CS_ANTICOLLISION   = 2;
   localparam int CS_GAIN_LOOP       = 1;
   localparam int CS_AUX_SYNTH       = 0;

   // ==========================================================
   // Interrupt register bit positions
   localparam int I1_TX       = 7;
   localparam int I1_RX       = 6;
   localparam int I1_FIFO     = 5;
   localparam int I1_ERR      = 4;
   localparam int I1_HEADER   = 3;
   localparam int I1_AUTOACK  = 1;
   localparam int I1_NORESP   = 0;
   localparam int I2_ANA      = 7;
   localparam int I2_CMD      = 6;
   localparam int I2_CRC      = 2;
   localparam int I2_LENGTH   = 1;
   localparam int I2_PREAMBLE = 0;

   // ==========================================================
   // Direct command codes
   localparam logic [7:0] CMD_HOP_MAIN     = 8'h84;
   localparam logic [7:0] CMD_HOP_AUX      = 8'h85;
   localparam logic [7:0] CMD_ADC          = 8'h87;
   localparam logic [7:0] CMD_FILTER_CAL   = 8'h88;
   localparam logic [7:0] CMD_AUTO_SUPPLY  = 8'ha2;
   localparam logic [7:0] CMD_MAN_SUPPLY   = 8'ha3;
   localparam logic [7:0] CMD_AUTO_OSC     = 8'ha4;
   localparam logic [7:0] CMD_MAN_OSC      = 8'ha5;
   localparam logic [7:0] CMD_GAIN_ON      = 8'ha6;
   localparam logic [7:0] CMD_GAIN_OFF     = 8'ha7;
   localparam logic [7:0] CMD_STORE_SS     = 8'ha8;
   localparam logic [7:0] CMD_CLEAR_SS     = 8'ha9;

   // ==========================================================
   // Pin synchroniser depth and pin indices
   localparam int SYNC_STAGES = 3;
   localparam int PIN_COUNT   = 4;
   localparam int PIN_CHIP_EN = 3;

endpackage : csie_pkg

// file: csie_top.sv
// Contract
// RL1: Signal-strength store/clear done sets bit 7, interrupts
// RL2: Oscillator range selection done sets bit 6, interrupts
// RL3: Supply level setting done sets bit 5, interrupts
// RL4: Filter calibration done sets bit 4, interrupts
// RL5: Conversion done sets bit 3, interrupts
// RL6: Bit 2 shows anti-collision support enabled
// RL7: Bit 1 follows gain loop on/off commands
// RL8: Bit 0 shows auxiliary synthesizer setting selected
// RL9: Fixed read-only version register
// RL10: First enable register gates first interrupt bits
// RL11: Status bits set regardless of enables
// RL12: No-response enable clear stops timer aborts
// RL13: Second enable register gates analog, command, errors
// RL14: Host keeps enable bits 5..3 at zero
// RL15: Pin high while any enabled status set
// RL16: Read, reset, chip disable clear interrupt registers
// RL17: Any error sets main and sub error bits
`timescale 1ns/1ps
`default_nettype none

module csie_top #(
   parameter logic [7:0] VERSION = csie_pkg::VERSION_DEFAULT  // Arbitrary value
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   input  wire logic        cmd_done,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        tx_end,
   input  wire logic        rx_end,
   input  wire logic        fifo_level_event,
   input  wire logic        header_event,
   input  wire logic        auto_ack_done,
   input  wire logic        noresp_timeout,
   input  wire logic        err_crc,
   input  wire logic        err_length,
   input  wire logic        err_preamble,
   input  wire logic        interrogator_anticollision_enabled,
   input  wire logic        osc_ok,
   input  wire logic        pll_ok,
   input  wire logic        rf_ok,
   input  wire logic        chip_en,
   output var  logic        irq,
   output var  logic        noresp_abort_enable
);

   // ==========================================================
   // Registers
   logic [7:0] cmd_status;
   logic [7:0] int_en1;
   logic [7:0] int_en2;
   logic [7:0] int_stat1;
   logic [7:0] int_stat2;

   // ==========================================================
   // Bus decode
   logic        xfer;
   logic        wr_ok;
   logic        rd_ok;
   logic        addr_aligned;
   logic [7:0]  rd_mux;
   logic        rd_clr_cs;
   logic        rd_clr_i1;
   logic        rd_clr_i2;

   // A transfer completes on the edge where the master sees waitrequest low
   assign xfer         = (avs_read | avs_write) & ~avs_waitrequest;
   assign addr_aligned = (avs_address[1:0] == 2'b00);
   assign wr_ok        = xfer & avs_write & avs_byteenable[0] & addr_aligned;
   assign rd_ok        = xfer & avs_read & addr_aligned;
   assign rd_clr_cs    = rd_ok & (avs_address == csie_pkg::ADDR_CMD_STATUS);
   assign rd_clr_i1    = rd_ok & (avs_address == csie_pkg::ADDR_INT_STAT1);
   assign rd_clr_i2    = rd_ok & (avs_address == csie_pkg::ADDR_INT_STAT2);

   always_comb begin
      rd_mux = 8'h00;
      if (addr_aligned) begin
         unique case (avs_address)
            csie_pkg::ADDR_CMD_STATUS: rd_mux = cmd_status;
            csie_pkg::ADDR_VERSION:    rd_mux = VERSION;    // [RL9]
            csie_pkg::ADDR_INT_EN1:    rd_mux = int_en1;
            csie_pkg::ADDR_INT_EN2:    rd_mux = int_en2;
            csie_pkg::ADDR_INT_STAT1:  rd_mux = int_stat1;
            csie_pkg::ADDR_INT_STAT2:  rd_mux = int_stat2;
            default:                   rd_mux = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Avalon slave handshake: one wait cycle, then completion
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if (xfer) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_read | avs_write) begin
         avs_waitrequest <= 1'b0;
      end
   end

   // The snapshot also tells the clear-on-read which bits the host saw
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & avs_waitrequest) begin
         avs_readdata <= {24'h00_0000, rd_mux};
      end
   end

   // ==========================================================
   // Pin synchronisers: osc_ok, pll_ok, rf_ok, chip_en
   logic [csie_pkg::PIN_COUNT-1:0] pin_raw;
   logic [csie_pkg::PIN_COUNT-1:0] pin_filt;
   logic [csie_pkg::PIN_COUNT-1:0] pin_change;

   assign pin_raw = {chip_en, rf_ok, pll_ok, osc_ok};

   genvar g;
   generate
      for (g = 0; g < csie_pkg::PIN_COUNT; g++) begin : g_pin
         logic [csie_pkg::SYNC_STAGES-1:0] stage;

         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               stage <= '0;
            end else begin
               stage <= {stage[csie_pkg::SYNC_STAGES-2:0], pin_raw[g]};
            end
         end

         // A new level counts once the second and third stages agree
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               pin_filt[g]   <= 1'b0;
               pin_change[g] <= 1'b0;
            end else begin
               pin_change[g] <= 1'b0;
               if (stage[1] == stage[2] && stage[2] != pin_filt[g]) begin
                  pin_filt[g]   <= stage[2];
                  pin_change[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   logic chip_enabled;
   logic ana_change;

   assign chip_enabled = pin_filt[csie_pkg::PIN_CHIP_EN];
   // Both edges of any analog status count as one event
   assign ana_change   = |pin_change[csie_pkg::PIN_CHIP_EN-1:0];

   // ==========================================================
   // Command completion decode
   logic ev_ss;
   logic ev_osc;
   logic ev_supply;
   logic ev_fcal;
   logic ev_adc;
   logic ev_irq_cmd;

   assign ev_ss     = cmd_done & (cmd_code == csie_pkg::CMD_STORE_SS
                                  | cmd_code == csie_pkg::CMD_CLEAR_SS);     // [RL1]
   assign ev_osc    = cmd_done & (cmd_code == csie_pkg::CMD_AUTO_OSC
                                  | cmd_code == csie_pkg::CMD_MAN_OSC);      // [RL2]
   assign ev_supply = cmd_done & (cmd_code == csie_pkg::CMD_AUTO_SUPPLY
                                  | cmd_code == csie_pkg::CMD_MAN_SUPPLY);   // [RL3]
   assign ev_fcal   = cmd_done & (cmd_code == csie_pkg::CMD_FILTER_CAL);    // [RL4]
   assign ev_adc    = cmd_done & (cmd_code == csie_pkg::CMD_ADC);           // [RL5]
   // Gain loop and frequency hop completions raise no interrupt
   assign ev_irq_cmd = ev_ss | ev_osc | ev_supply | ev_fcal | ev_adc;        // [RL1] [RL2] [RL3] [RL4] [RL5]

   // ==========================================================
   // Command status register
   logic [7:0] cs_set;
   logic [7:0] cs_keep;

   always_comb begin
      cs_set = 8'h00;
      cs_set[csie_pkg::CS_SIGNAL_STRENGTH] = ev_ss;                          // [RL1]
      cs_set[csie_pkg::CS_OSC_RANGE]       = ev_osc;                         // [RL2]
      cs_set[csie_pkg::CS_SUPPLY_LEVEL]    = ev_supply;                      // [RL3]
      cs_set[csie_pkg::CS_FILTER_CAL]      = ev_fcal;                        // [RL4]
      cs_set[csie_pkg::CS_ADC]             = ev_adc;                         // [RL5]
   end

   // Only bits the host actually saw are cleared; a new set wins
   assign cs_keep = rd_clr_cs ? ~avs_readdata[7:0] : 8'hff;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_status[7:3] <= csie_pkg::CMD_STATUS_RESET[7:3];
      end else begin
         cmd_status[7:3] <= (cmd_status[7:3] & cs_keep[7:3]) | cs_set[7:3];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_status[csie_pkg::CS_ANTICOLLISION] <= 1'b0;
      end else begin
         cmd_status[csie_pkg::CS_ANTICOLLISION] <= interrogator_anticollision_enabled; // [RL6]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_status[csie_pkg::CS_GAIN_LOOP] <= 1'b0;
      end else if (cmd_done && cmd_code == csie_pkg::CMD_GAIN_ON) begin
         cmd_status[csie_pkg::CS_GAIN_LOOP] <= 1'b1;                         // [RL7]
      end else if (cmd_done && cmd_code == csie_pkg::CMD_GAIN_OFF) begin
         cmd_status[csie_pkg::CS_GAIN_LOOP] <= 1'b0;                         // [RL7]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_status[csie_pkg::CS_AUX_SYNTH] <= 1'b0;
      end else if (cmd_done && cmd_code == csie_pkg::CMD_HOP_AUX) begin
         cmd_status[csie_pkg::CS_AUX_SYNTH] <= 1'b1;                         // [RL8]
      end else if (cmd_done && cmd_code == csie_pkg::CMD_HOP_MAIN) begin
         cmd_status[csie_pkg::CS_AUX_SYNTH] <= 1'b0;                         // [RL8]
      end
   end

   // ==========================================================
   // Interrupt enable registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_en1 <= csie_pkg::INT_EN1_RESET;
      end else if (wr_ok && avs_address == csie_pkg::ADDR_INT_EN1) begin
         int_en1 <= avs_writedata[7:0];                                      // [RL10]
      end
   end

   // Reserved bits are held at zero even if the host writes ones
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_en2 <= csie_pkg::INT_EN2_RESET;
      end else if (wr_ok && avs_address == csie_pkg::ADDR_INT_EN2) begin
         int_en2 <= avs_writedata[7:0] & csie_pkg::INT_EN2_WRITABLE;         // [RL13] [RL14]
      end
   end

   // Receive logic may only abort on the no-response timer while enabled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         noresp_abort_enable <= csie_pkg::INT_EN1_RESET[csie_pkg::I1_NORESP];
      end else begin
         noresp_abort_enable <= int_en1[csie_pkg::I1_NORESP];                // [RL12]
      end
   end

   // ==========================================================
   // Interrupt status registers
   logic       err_any;
   logic [7:0] i1_set;
   logic [7:0] i2_set;
   logic [7:0] i1_keep;
   logic [7:0] i2_keep;

   assign err_any = err_crc | err_length | err_preamble;                     // [RL17]

   always_comb begin
      i1_set = 8'h00;
      i1_set[csie_pkg::I1_TX]      = tx_end;
      i1_set[csie_pkg::I1_RX]      = rx_end;
      i1_set[csie_pkg::I1_FIFO]    = fifo_level_event;
      i1_set[csie_pkg::I1_ERR]     = err_any;                                // [RL17]
      i1_set[csie_pkg::I1_HEADER]  = header_event;
      i1_set[csie_pkg::I1_AUTOACK] = auto_ack_done;
      i1_set[csie_pkg::I1_NORESP]  = noresp_timeout;
   end

   always_comb begin
      i2_set = 8'h00;
      i2_set[csie_pkg::I2_ANA]      = ana_change;
      i2_set[csie_pkg::I2_CMD]      = ev_irq_cmd;
      i2_set[csie_pkg::I2_CRC]      = err_crc;                               // [RL17]
      i2_set[csie_pkg::I2_LENGTH]   = err_length;                            // [RL17]
      i2_set[csie_pkg::I2_PREAMBLE] = err_preamble;                          // [RL17]
   end

   // Clear only what the read returned, so an event during the read survives
   assign i1_keep = rd_clr_i1 ? ~avs_readdata[7:0] : 8'hff;                  // [RL16]
   assign i2_keep = rd_clr_i2 ? ~avs_readdata[7:0] : 8'hff;                  // [RL16]

   // Status bits ignore the enables; chip disable holds them cleared
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_stat1 <= csie_pkg::INT_STAT_RESET;
      end else if (!chip_enabled) begin
         int_stat1 <= csie_pkg::INT_STAT_RESET;                              // [RL16]
      end else begin
         int_stat1 <= (int_stat1 & i1_keep) | i1_set;                        // [RL11]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_stat2 <= csie_pkg::INT_STAT_RESET;
      end else if (!chip_enabled) begin
         int_stat2 <= csie_pkg::INT_STAT_RESET;                              // [RL16]
      end else begin
         int_stat2 <= (int_stat2 & i2_keep) | i2_set;                        // [RL11]
      end
   end

   // ==========================================================
   // Interrupt pin: level, one cycle behind the status bits
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= chip_enabled & ((|(int_stat1 & int_en1))                     // [RL10]
                              | (|(int_stat2 & int_en2)));                   // [RL13] [RL15]
      end
   end

endmodule : csie_top

`default_nettype wire

// file: csie_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bus, interrupt pin and no-response abort enable checks
module csie_top_assertions #(
   parameter logic [7:0] VERSION = csie_pkg::VERSION_DEFAULT
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        chip_en,
   input wire logic        irq,
   input wire logic        noresp_abort_enable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic done_rd;
   logic done_wr;
   assign done_rd = avs_read && !avs_waitrequest;
   assign done_wr = avs_write && !avs_waitrequest;
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   // Quiet means no bus traffic that could move irq on its own
   sequence s_quiet_high;
      chip_en [*6] ##0 (irq && !avs_read && !$past(avs_read) && !avs_write && !$past(avs_write));
   endsequence
   chk_bus_one_wait: assert property (s_req |=> s_ans)
      else $error("bus answer not after one wait state");
   chk_version_read: assert property (done_rd && avs_address == csie_pkg::ADDR_VERSION |->
      avs_readdata[7:0] == VERSION)
      else $error("version read wrong");
   chk_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   chk_en2_reserved: assert property (done_rd && avs_address == csie_pkg::ADDR_INT_EN2 |->
      avs_readdata[5:3] == 3'h0)
      else $error("second enable reserved bits not zero");
   chk_noresp_follow: assert property (done_wr && avs_address == csie_pkg::ADDR_INT_EN1 &&
      avs_byteenable[0] |=> ##1 noresp_abort_enable == $past(avs_writedata[0], 2))
      else $error("abort enable does not follow enable bit 0");
   chk_chip_off: assert property (!chip_en [*8] |-> !irq)
      else $error("irq high while chip disabled");
   chk_reset_quiet: assert property ($fell(rst) |-> !irq [*3])
      else $error("irq high right after reset");
   chk_irq_hold: assert property (s_quiet_high |=> irq)
      else $error("irq dropped with no clearing access");
endmodule : csie_top_assertions
`default_nettype wire

// file: csie_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Host microcontroller model on the register bus
module csie_host (
   input  wire logic        mclk,
   output var  logic [7:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   output var  logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hf;
   end
   // Waits for the answer with a bound; ok low means it never came
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h000000, (a == csie_pkg::ADDR_INT_EN2) ? (d & 8'hc7) : d};
      avs_write <= w;
      avs_read <= !w;
      ok = 1'b0;
      q = 8'h00;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge mclk);
         ok = !avs_waitrequest;
         q = avs_readdata[7:0];
      end
      // Released lines show garbage, not the last value
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~avs_writedata;
   endtask : access
endmodule : csie_host
`default_nettype wire

// file: csie_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module csie_tb_top;
   localparam logic [7:0] VER = 8'h3c;  // Arbitrary value
   localparam logic [7:0] A_CS = csie_pkg::ADDR_CMD_STATUS;
   localparam logic [7:0] A_E1 = csie_pkg::ADDR_INT_EN1;
   localparam logic [7:0] A_E2 = csie_pkg::ADDR_INT_EN2;
   localparam logic [7:0] A_I1 = csie_pkg::ADDR_INT_STAT1;
   localparam logic [7:0] A_I2 = csie_pkg::ADDR_INT_STAT2;
   logic        mclk = 1'b0;
   logic        rst, cmd_done, ac, chip_en, irq, nae, ok, gain, aux, wt;
   logic [7:0]  avs_address, cmd_code, q, c, e1, e2;
   logic        avs_read, avs_write;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [8:0]  ev;
   logic [2:0]  ana;
   logic [15:0] m;
   int          failures = 0;
   int          n_tests = 0;
   int          seed = 32'hd3d54128;
   int          i;
   logic [7:0]  codes [12] = '{8'h84, 8'h85, 8'h87, 8'h88, 8'ha2, 8'ha3,
                                8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9};
   always #5 mclk = ~mclk;
   csie_host u_host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(wt));
   csie_top #(.VERSION(VER)) u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(wt),
      .cmd_done(cmd_done), .cmd_code(cmd_code), .tx_end(ev[0]), .rx_end(ev[1]),
      .fifo_level_event(ev[2]), .header_event(ev[3]), .auto_ack_done(ev[4]),
      .noresp_timeout(ev[5]), .err_crc(ev[6]), .err_length(ev[7]), .err_preamble(ev[8]),
      .interrogator_anticollision_enabled(ac), .osc_ok(ana[0]), .pll_ok(ana[1]),
      .rf_ok(ana[2]), .chip_en(chip_en), .irq(irq), .noresp_abort_enable(nae));
   // ====
   // Expectation helpers
   function automatic logic [7:0] sticky(input logic [7:0] code);
      case (code)
         8'ha8, 8'ha9: return 8'h80;
         8'ha4, 8'ha5: return 8'h40;
         8'ha2, 8'ha3: return 8'h20;
         8'h88: return 8'h10;
         8'h87: return 8'h08;
         default: return 8'h00;
      endcase
   endfunction : sticky
   // Errors land in both registers: main bit and one sub-bit
   function automatic logic [15:0] ev_map(input int k);
      logic [7:0] b1 [9] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02, 8'h01, 8'h10, 8'h10, 8'h10};
      logic [7:0] b2 [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h01};
      return {b1[k], b2[k]};
   endfunction : ev_map
   task automatic wrap_up();
      $display("failures %0d comparisons %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      u_host.access(w, a, d, q, ok);
      if (!ok) begin
         failures++;
         $display("unexpected at %0t: no bus answer", $time);
         wrap_up();
      end
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(q, exp);
   endtask : rdchk
   // Pulse lasts one cycle; three more edges let status and irq land
   task automatic fire(input logic [8:0] mask, input logic done, input logic [7:0] code);
      @(posedge mclk);
      ev <= mask;
      cmd_done <= done;
      cmd_code <= code;
      @(posedge mclk);
      ev <= 9'h000;
      cmd_done <= 1'b0;
      cmd_code <= ~code;
      repeat (3) @(posedge mclk);
   endtask : fire
   // ====
   // Main sequence
   initial begin
      rst = 1'b1;
      {cmd_done, ac, chip_en, gain, aux} = 5'h00;
      cmd_code = 8'h00;
      ev = 9'h000;
      ana = 3'h0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rdchk(A_E1, 8'hfb);
      rdchk(A_E2, 8'h40);
      rdchk(csie_pkg::ADDR_VERSION, VER);
      bus(1'b1, csie_pkg::ADDR_VERSION, ~VER);
      rdchk(csie_pkg::ADDR_VERSION, VER);
      rdchk(A_CS, 8'h00);
      rdchk(8'h04, 8'h00);
      check({7'h0, nae}, 8'h01);
      $display("test reset done");
      chip_en <= 1'b1;
      repeat (8) @(posedge mclk);
      for (int k = 0; k < 24; k++) begin
         c = (k < 12) ? codes[k] : codes[$unsigned($random(seed)) % 12];
         ac <= 1'($random(seed));
         fire(9'h000, 1'b1, c);
         if (c == 8'ha6 || c == 8'ha7) gain = (c == 8'ha6);
         if (c == 8'h84 || c == 8'h85) aux = (c == 8'h85);
         check({7'h0, irq}, {7'h0, sticky(c) != 8'h00});
         rdchk(A_CS, sticky(c) | {5'h0, ac, gain, aux});
         rdchk(A_I2, (sticky(c) != 8'h00) ? 8'h40 : 8'h00);
         repeat (2) @(posedge mclk);
         check({7'h0, irq}, 8'h00);
      end
      $display("test commands done");
      for (int k = 0; k < 30; k++) begin
         i = (k < 9) ? k : $unsigned($random(seed)) % 9;
         e1 = 8'($random(seed));
         e2 = 8'($random(seed));
         bus(1'b1, A_E1, e1);
         bus(1'b1, A_E2, e2);
         fire(9'h001 << i, 1'b0, 8'h00);
         m = ev_map(i);
         check({7'h0, irq}, {7'h0, |((m[15:8] & e1) | (m[7:0] & e2 & 8'hc7))});
         check({7'h0, nae}, {7'h0, e1[0]});
         rdchk(A_E2, e2 & 8'hc7);
         rdchk(A_I1, m[15:8]);
         rdchk(A_I2, m[7:0]);
      end
      $display("test events done");
      bus(1'b1, A_E1, 8'hff);
      fire(9'h001, 1'b0, 8'h00);
      check({7'h0, irq}, 8'h01);
      chip_en <= 1'b0;
      repeat (8) @(posedge mclk);
      check({7'h0, irq}, 8'h00);
      rdchk(A_I1, 8'h00);
      chip_en <= 1'b1;
      repeat (8) @(posedge mclk);
      $display("test chip disable done");
      bus(1'b1, A_E2, 8'h80);
      ana <= 3'h2;
      repeat (8) @(posedge mclk);
      check({7'h0, irq}, 8'h01);
      rdchk(A_I2, 8'h80);
      $display("test analog done");
      wrap_up();
   end
endmodule : csie_tb_top
bind csie_top csie_top_assertions #(.VERSION(VERSION)) u_chk (.mclk(mclk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chip_en(chip_en),
   .irq(irq), .noresp_abort_enable(noresp_abort_enable));
`default_nettype wire
